// [design/fpc_pkg.sv]
// Purpose: Shared constants and types for the flash protection control block.
// Assumes: Eight-bit stored password, up to ten data sectors on small-flash variants.
// Notes: Password pattern fields are given as bit positions and codes.
package fpc_pkg;
	localparam int          FPC_PW_W         = 8;
	localparam int          FPC_PW_MSB       = 7;
	localparam int          FPC_PW_N_HI      = 6;
	localparam int          FPC_PW_N_LO      = 3;
	localparam int          FPC_SEC_N        = 10;
	localparam logic [3:0]  FPC_N_MIN        = 4'h1;
	localparam logic [3:0]  FPC_N_MAX        = 4'h9;
	localparam logic [4:0]  FPC_PAT_ALL      = 5'h0A;
	localparam logic [7:0]  FPC_PW_RST       = 8'h00;
	localparam logic [9:0]  FPC_SEC_ALL      = 10'h3FF;
	localparam logic [9:0]  FPC_SEC_NONE     = 10'h000;
	localparam logic [3:0]  FPC_LDR_MODE_PW  = 4'h6;

	typedef enum logic [3:0]
	{
		FPC_ST_IDLE  = 4'b0001,
		FPC_ST_ERASE = 4'b0010,
		FPC_ST_CLRPW = 4'b0100,
		FPC_ST_DONE  = 4'b1000
	} fpc_state_t;
endpackage : fpc_pkg

// [design/fpc_decode.sv]
// Purpose: Decodes a stored password into protection mode and sector scope.
// Assumes: Purely combinational; the caller latches the results.
// Notes: Small-flash variant decoding follows the sector pattern table.
`timescale 1ns/1ps
`default_nettype none
module fpc_decode
	import fpc_pkg::*;
(
	input  wire logic [7:0] password,
	input  wire logic       small_variant,
	output logic            mode1,
	output logic            read_prot,
	output logic [9:0]      erase_sectors
);
	logic [3:0] n_field;
	logic [4:0] pat;

	// Sector mask with bits 0 to n-1 set.
	function automatic logic [9:0] fpc_low_mask(input logic [3:0] n);
		logic [9:0] m;
		m = FPC_SEC_NONE;
		for (int i = 0; i < FPC_SEC_N; i++)
		begin
			if (4'(i) < n)
				m[i] = 1'b1;
		end
		return m;
	endfunction

	always_comb
	begin
		n_field       = password[FPC_PW_N_HI:FPC_PW_N_LO];
		pat           = password[FPC_PW_MSB:FPC_PW_N_LO];
		mode1         = password[FPC_PW_MSB];
		read_prot     = 1'b1;
		erase_sectors = FPC_SEC_ALL;
		if (small_variant)
		begin
			if (password[FPC_PW_MSB])
			begin
				read_prot     = 1'b1;
				erase_sectors = FPC_SEC_ALL;
			end
			else if (pat == FPC_PAT_ALL)
			begin
				read_prot     = 1'b0;
				erase_sectors = FPC_SEC_ALL;
			end
			else if (n_field >= FPC_N_MIN && n_field <= FPC_N_MAX)
			begin
				read_prot     = 1'b0;
				erase_sectors = fpc_low_mask(n_field);
			end
			else
			begin
				read_prot     = 1'b0;
				erase_sectors = FPC_SEC_NONE;
			end
		end
	end
endmodule // fpc_decode
`default_nettype wire

// [design/fpc_top.sv]
// Purpose: Flash protection control: gates core reads, programs and erases of the flash arrays.
// Assumes: Password and variant straps come from nonvolatile storage, stable around reset.
// Notes: Unlock erases the scoped contents, then the password; protection holds until next reset.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Mask ROM program memory is always read-out protected.
// - Arming and unlocking happen only through bootstrap loader mode 6.
// - Password MSB one: mode 1, both flashes protected, unlock erases all.
// - Password MSB zero: mode 0, program flash only, unlock erases it.
// - Program flash reads served to code in program flash, or either in mode 1.
// - Mode 0 data flash is readable from any program memory.
// - Program flash program and erase refused while protected.
// - Mode 0 data program allowed, erase needs enable bit; mode 1 refuses both.
// - Password match erases protected contents and the stored password.
// - After unlock protection holds until next reset, then unprotected.
// - Small variants: MSB one protects whole flash, unlock erases all sectors.
// - Small variants: n from 1 to 9 erase-protects sectors 0 to n-1.
// - Pattern 01010 protects all sectors; other patterns protect nothing.
module fpc_top
	import fpc_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       nrst,
	input  wire logic       clk_en,
	input  wire logic       small_variant,
	input  wire logic       pw_stored_valid,
	input  wire logic [7:0] pw_stored,
	input  wire logic       bootstrap_loader_active,
	input  wire logic [3:0] bootstrap_loader_mode,
	input  wire logic       pw_program_req,
	input  wire logic       unlock_req,
	input  wire logic [7:0] unlock_pw,
	input  wire logic       rd_req,
	input  wire logic       rd_tgt_pflash,
	input  wire logic       rd_tgt_dflash,
	input  wire logic       rd_tgt_rom,
	input  wire logic       rd_exec_pflash,
	input  wire logic       rd_exec_dflash,
	input  wire logic       rd_external,
	input  wire logic       pe_req,
	input  wire logic       pe_erase,
	input  wire logic       pe_tgt_pflash,
	input  wire logic [9:0] pe_sectors,
	input  wire logic       data_flash_erase_enable,
	input  wire logic       erase_done,
	input  wire logic       pw_clear_done,
	output logic            rd_grant,
	output logic            rd_deny,
	output logic            pe_grant,
	output logic            pe_deny,
	output logic            pw_program_grant,
	output logic            erase_start,
	output logic            erase_pflash,
	output logic            erase_dflash,
	output logic [9:0]      erase_sector_mask,
	output logic            pw_clear_start,
	output logic            unlock_ok,
	output logic            unlock_fail,
	output logic            prot_active,
	output logic            prot_mode1
);
	logic       dec_mode1;
	logic       dec_rprot;
	logic [9:0] dec_sec;

	logic       armed_q,  armed_d;
	logic       mode1_q,  mode1_d;
	logic       rprot_q,  rprot_d;
	logic [9:0] scope_q,  scope_d;
	logic [7:0] pw_q,     pw_d;
	logic       latch_q,  latch_d;
	fpc_state_t st_q,     st_d;

	logic rd_grant_q, rd_grant_d, rd_deny_q, rd_deny_d;
	logic pe_grant_q, pe_grant_d, pe_deny_q, pe_deny_d;
	logic pwg_q, pwg_d, es_q, es_d, ep_q, ep_d, ed_q, ed_d;
	logic [9:0] esm_q, esm_d;
	logic pcs_q, pcs_d, uok_q, uok_d, ufl_q, ufl_d;

	logic ldr_ok;
	logic pf_readable;
	logic df_readable;
	logic pe_ok;

	fpc_decode u_decode
	(
		.password      (pw_stored),
		.small_variant (small_variant),
		.mode1         (dec_mode1),
		.read_prot     (dec_rprot),
		.erase_sectors (dec_sec)
	);

	// Protection configuration: captured in the first enabled cycle after reset release.
	always_comb
	begin
		latch_d = 1'b1;
		armed_d = armed_q;
		mode1_d = mode1_q;
		rprot_d = rprot_q;
		scope_d = scope_q;
		pw_d    = pw_q;
		if (!latch_q)
		begin
			armed_d = pw_stored_valid;
			mode1_d = dec_mode1;
			rprot_d = dec_rprot;
			scope_d = dec_sec;
			pw_d    = pw_stored;
		end
	end

	always_comb
	begin
		ldr_ok = bootstrap_loader_active && (bootstrap_loader_mode == FPC_LDR_MODE_PW);
		// Read access decision.
		pf_readable = !armed_q || !rprot_q || rd_exec_pflash || (mode1_q && rd_exec_dflash);
		if (small_variant)
			pf_readable = !armed_q || !rprot_q || rd_exec_pflash || rd_exec_dflash;
		df_readable = !armed_q || !rprot_q || !mode1_q || rd_exec_pflash || rd_exec_dflash;
		// Program/erase decision; protection stays in force after unlock until reset.
		if (!armed_q)
			pe_ok = 1'b1;
		else if (small_variant)
			pe_ok = !rprot_q && !(pe_erase && |(pe_sectors & scope_q));
		else if (pe_tgt_pflash)
			pe_ok = 1'b0;
		else if (mode1_q)
			pe_ok = 1'b0;
		else
			pe_ok = !pe_erase || data_flash_erase_enable;
	end

	// Access gating and unlock sequencing.
	always_comb
	begin
		st_d       = st_q;
		rd_grant_d = 1'b0;
		rd_deny_d  = 1'b0;
		pe_grant_d = 1'b0;
		pe_deny_d  = 1'b0;
		pwg_d      = 1'b0;
		es_d       = 1'b0;
		pcs_d      = 1'b0;
		uok_d      = 1'b0;
		ufl_d      = 1'b0;
		ep_d       = ep_q;
		ed_d       = ed_q;
		esm_d      = esm_q;
		if (rd_req && latch_q)
		begin
			if (rd_external && (rd_tgt_rom || rd_tgt_pflash || rd_tgt_dflash) && rd_tgt_rom)
				rd_deny_d = 1'b1;
			else if (rd_tgt_rom)
				rd_grant_d = !rd_external;
			else if (rd_tgt_pflash)
			begin
				rd_grant_d = pf_readable && !(rd_external && armed_q && rprot_q);
				rd_deny_d  = !(pf_readable && !(rd_external && armed_q && rprot_q));
			end
			else
			begin
				rd_grant_d = df_readable && !(rd_external && armed_q && rprot_q && mode1_q);
				rd_deny_d  = !(df_readable && !(rd_external && armed_q && rprot_q && mode1_q));
			end
			if (rd_tgt_rom && rd_external)
				rd_grant_d = 1'b0;
		end
		if (pe_req && latch_q && st_q == FPC_ST_IDLE)
		begin
			pe_grant_d = pe_ok;
			pe_deny_d  = !pe_ok;
		end
		else if (pe_req)
			pe_deny_d = 1'b1;
		if (pw_program_req && latch_q)
			pwg_d = ldr_ok && !armed_q;
		case (st_q)
			FPC_ST_IDLE:
			begin
				if (unlock_req && latch_q && ldr_ok && armed_q)
				begin
					if (unlock_pw == pw_q)
					begin
						es_d  = 1'b1;
						ep_d  = 1'b1;
						ed_d  = small_variant || mode1_q;
						esm_d = small_variant ? scope_q : FPC_SEC_ALL;
						st_d  = FPC_ST_ERASE;
					end
					else
						ufl_d = 1'b1;
				end
				else if (unlock_req)
					ufl_d = 1'b1;
			end
			FPC_ST_ERASE:
			begin
				// Only one unlock sequence runs at a time; a second request is refused.
				ufl_d = unlock_req;
				if (erase_done)
				begin
					pcs_d = 1'b1;
					st_d  = FPC_ST_CLRPW;
				end
			end
			FPC_ST_CLRPW:
			begin
				ufl_d = unlock_req;
				if (pw_clear_done)
				begin
					uok_d = 1'b1;
					st_d  = FPC_ST_DONE;
				end
			end
			FPC_ST_DONE:
			begin
				// Stays armed until reset; a repeated unlock is refused.
				ufl_d = unlock_req;
			end
			default:
			begin
				st_d = FPC_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			latch_q    <= 1'b0;
			armed_q    <= 1'b1;
			mode1_q    <= 1'b1;
			rprot_q    <= 1'b1;
			scope_q    <= FPC_SEC_ALL;
			pw_q       <= FPC_PW_RST;
			st_q       <= FPC_ST_IDLE;
			rd_grant_q <= 1'b0;
			rd_deny_q  <= 1'b0;
			pe_grant_q <= 1'b0;
			pe_deny_q  <= 1'b0;
			pwg_q      <= 1'b0;
			es_q       <= 1'b0;
			ep_q       <= 1'b0;
			ed_q       <= 1'b0;
			esm_q      <= FPC_SEC_NONE;
			pcs_q      <= 1'b0;
			uok_q      <= 1'b0;
			ufl_q      <= 1'b0;
		end
		else if (clk_en)
		begin
			latch_q    <= latch_d;
			armed_q    <= armed_d;
			mode1_q    <= mode1_d;
			rprot_q    <= rprot_d;
			scope_q    <= scope_d;
			pw_q       <= pw_d;
			st_q       <= st_d;
			rd_grant_q <= rd_grant_d;
			rd_deny_q  <= rd_deny_d;
			pe_grant_q <= pe_grant_d;
			pe_deny_q  <= pe_deny_d;
			pwg_q      <= pwg_d;
			es_q       <= es_d;
			ep_q       <= ep_d;
			ed_q       <= ed_d;
			esm_q      <= esm_d;
			pcs_q      <= pcs_d;
			uok_q      <= uok_d;
			ufl_q      <= ufl_d;
		end
	end

	assign rd_grant          = rd_grant_q;
	assign rd_deny           = rd_deny_q;
	assign pe_grant          = pe_grant_q;
	assign pe_deny           = pe_deny_q;
	assign pw_program_grant  = pwg_q;
	assign erase_start       = es_q;
	assign erase_pflash      = ep_q;
	assign erase_dflash      = ed_q;
	assign erase_sector_mask = esm_q;
	assign pw_clear_start    = pcs_q;
	assign unlock_ok         = uok_q;
	assign unlock_fail       = ufl_q;
	assign prot_active       = armed_q;
	assign prot_mode1        = mode1_q;
endmodule // fpc_top
`default_nettype wire

// [bench/fpc_flash_model.sv]
// Purpose: Flash array stand-in that answers erase and password-clear starts.
// Assumes: One operation at a time; lat sets the answer delay in cycles.
// Notes: Done pulses last one cycle; lat of zero answers on the next edge.
`timescale 1ns/1ps
`default_nettype none
module fpc_flash_model
(
	input  wire logic       clk,
	input  wire logic       nrst,
	input  wire logic       erase_start,
	input  wire logic       pw_clear_start,
	input  wire logic [3:0] lat,
	output logic            erase_done,
	output logic            pw_clear_done
);
	logic [4:0] cnt_q;
	logic       clr_q;

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			cnt_q <= '0;
			clr_q <= 1'b0;
			erase_done <= 1'b0;
			pw_clear_done <= 1'b0;
		end
		else
		begin
			erase_done <= 1'b0;
			pw_clear_done <= 1'b0;
			if (erase_start || pw_clear_start)
			begin
				cnt_q <= {1'b0, lat} + 5'h01;
				clr_q <= pw_clear_start;
			end
			else if (cnt_q == 5'h01)
			begin
				erase_done <= !clr_q;
				pw_clear_done <= clr_q;
				cnt_q <= '0;
			end
			else if (cnt_q != 5'h00)
				cnt_q <= cnt_q - 5'h01;
		end
	end
endmodule // fpc_flash_model
`default_nettype wire

// [bench/fpc_top_props.sv]
// Purpose: Port-level checks of the flash protection control block.
// Assumes: Requests count from the second enabled edge after reset.
// Notes: Bound into fpc_top below.
`timescale 1ns/1ps
`default_nettype none
module fpc_top_props
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic clk_en,
	input wire logic small_variant,
	input wire logic rd_req,
	input wire logic rd_tgt_rom,
	input wire logic rd_external,
	input wire logic pe_req,
	input wire logic pe_erase,
	input wire logic pe_tgt_pflash,
	input wire logic data_flash_erase_enable,
	input wire logic unlock_req,
	input wire logic erase_done,
	input wire logic pw_clear_done,
	input wire logic rd_grant,
	input wire logic rd_deny,
	input wire logic pe_grant,
	input wire logic pe_deny,
	input wire logic erase_start,
	input wire logic erase_pflash,
	input wire logic erase_dflash,
	input wire logic pw_clear_start,
	input wire logic unlock_ok,
	input wire logic unlock_fail,
	input wire logic prot_active,
	input wire logic prot_mode1
);
	logic rdy_q;
	logic rdy_d;
	logic go;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	always_comb rdy_d = rdy_q | clk_en;
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			rdy_q <= 1'b0;
		else
			rdy_q <= rdy_d;
	end
	assign go = rdy_q & clk_en;

	a_read_answer: assert property (go && rd_req |=> rd_grant ^ rd_deny)
		else $error("read got no single answer");
	a_rom_ext_deny: assert property (go && rd_req && rd_tgt_rom && rd_external |=> rd_deny && !rd_grant)
		else $error("rom read by external path not denied");
	a_pflash_pe_deny: assert property (go && pe_req && pe_tgt_pflash && prot_active && !small_variant |=> pe_deny)
		else $error("program flash change not denied");
	a_mode1_df_deny: assert property (go && pe_req && prot_active && prot_mode1 && !small_variant |=> pe_deny)
		else $error("data flash change in mode 1 not denied");
	a_df_erase_gate: assert property (go && pe_req && pe_erase && !data_flash_erase_enable && prot_active
		&& !small_variant |=> pe_deny)
		else $error("data flash erase without enable not denied");
	a_unlock_answer: assert property (go && unlock_req |=> erase_start ^ unlock_fail)
		else $error("unlock got no single answer");
	a_clear_follows: assert property (go && erase_done |=> pw_clear_start ##1 !pw_clear_start)
		else $error("password clear did not follow erase");
	a_ok_follows: assert property (go && pw_clear_done |=> unlock_ok)
		else $error("unlock ok did not follow password clear");
	a_bank_scope: assert property (erase_start && !small_variant |-> erase_pflash && erase_dflash == prot_mode1)
		else $error("bank erase scope wrong");
	a_mode_held: assert property (rdy_q |=> $stable(prot_mode1) && $stable(prot_active))
		else $error("protection state changed before reset");
endmodule // fpc_top_props
bind fpc_top fpc_top_props u_props(.*);
`default_nettype wire

// [bench/flash_protection_control_tb.sv]
// Purpose: Self-checking bench for fpc_top with a flash stand-in.
// Assumes: clk_en high except for one freeze check; answers checked from queues by a monitor.
// Notes: Each straps setting is entered through a fresh reset.
`timescale 1ns/1ps
`default_nettype none
module flash_protection_control_tb;
	logic clk, nrst, clk_en, small_variant, pw_stored_valid, bootstrap_loader_active, pw_program_req, unlock_req;
	logic rd_req, rd_tgt_pflash, rd_tgt_dflash, rd_tgt_rom, rd_exec_pflash, rd_exec_dflash, rd_external;
	logic pe_req, pe_erase, pe_tgt_pflash, data_flash_erase_enable, erase_done, pw_clear_done;
	logic rd_grant, rd_deny, pe_grant, pe_deny, pw_program_grant, erase_start, erase_pflash, erase_dflash;
	logic pw_clear_start, unlock_ok, unlock_fail, prot_active, prot_mode1;
	logic [7:0] pw_stored, unlock_pw, p;
	logic [3:0] bootstrap_loader_mode, lat;
	logic [9:0] pe_sectors, erase_sector_mask;
	logic [1:0] q_rd[$], q_pe[$], q_ul[$], q_pw[$];
	int failures, n_compared, r;

	fpc_top uut(.*);
	fpc_flash_model u_flash(.*);

	initial
	begin
		clk = 0;
		forever #12.5 clk = ~clk;
	end

	task automatic chk(input logic [11:0] e, input logic [11:0] g);
		n_compared++;
		if (e !== g)
		begin
			failures++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask

	task automatic take(ref logic [1:0] q[$], input logic [1:0] g);
		if (q.size() == 0)
			chk(0, g);
		else
			chk(q.pop_front(), g);
	endtask

	task automatic boot(input logic sv, input logic v, input logic [7:0] pw);
		nrst = 0;
		{small_variant, pw_stored_valid, pw_stored} = {sv, v, pw};
		{bootstrap_loader_active, bootstrap_loader_mode} = 5'h00;
		repeat (2) @(posedge clk) #2;
		chk(12'h003, 12'({prot_active, prot_mode1}));
		nrst = 1;
		repeat (2) @(posedge clk) #2;
		chk(12'({v, pw[7]}), 12'({prot_active, prot_mode1}));
	endtask

	task automatic rd(input logic [5:0] s, input logic [1:0] e);
		{rd_tgt_pflash, rd_tgt_dflash, rd_tgt_rom, rd_exec_pflash, rd_exec_dflash, rd_external} = s;
		rd_req = 1;
		q_rd.push_back(e);
		@(posedge clk) #2;
	endtask

	task automatic pe(input logic [2:0] s, input logic [9:0] sec, input logic [1:0] e);
		{pe_erase, pe_tgt_pflash, data_flash_erase_enable} = s;
		pe_sectors = sec;
		pe_req = 1;
		q_pe.push_back(e);
		@(posedge clk) #2;
	endtask

	task automatic arm(input logic [3:0] m, input logic e);
		{bootstrap_loader_active, bootstrap_loader_mode} = {1'b1, m};
		pw_program_req = 1;
		if (e)
			q_pw.push_back(2'h2);
		@(posedge clk) #2;
		pw_program_req = 0;
		@(posedge clk) #2;
	endtask

	task automatic ul(input logic [7:0] pw, input logic [3:0] m, input logic ok, input logic [11:0] fx,
		input logic [11:0] cm);
		int i;
		i = 0;
		{bootstrap_loader_active, bootstrap_loader_mode, unlock_pw} = {1'b1, m, pw};
		lat = 4'($urandom % 8);
		unlock_req = 1;
		q_ul.push_back({ok, !ok});
		@(posedge clk) #2;
		unlock_req = 0;
		if (ok)
		begin
			while (erase_start !== 1'b1 && i < 4)
			begin
				@(posedge clk) #2;
				i++;
			end
			chk(fx & cm, {erase_pflash, erase_dflash, erase_sector_mask} & cm);
			while (unlock_ok !== 1'b1 && i < 40)
			begin
				@(posedge clk) #2;
				i++;
			end
		end
		else
			repeat (2) @(posedge clk) #2;
	endtask

	task automatic results();
		$display("compared %0d, failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	always @(posedge clk)
	begin
		#1;
		if ((rd_grant | rd_deny) !== 1'b0) take(q_rd, {rd_grant, rd_deny});
		if ((pe_grant | pe_deny) !== 1'b0) take(q_pe, {pe_grant, pe_deny});
		if ((unlock_ok | unlock_fail) !== 1'b0) take(q_ul, {unlock_ok, unlock_fail});
		if (pw_program_grant !== 1'b0) take(q_pw, {pw_program_grant, 1'b0});
	end

	initial
	begin
		#100000;
		failures++;
		results();
	end

	initial
	begin
		{failures, n_compared, lat, p} = '0;
		{clk_en, nrst, pw_program_req, unlock_req, unlock_pw, rd_req, pe_req} = 14'h2000;
		r = $urandom(94944);
		boot(0, 1, 8'h35);
		rd(6'h24, 2'h2);
		rd(6'h22, 2'h1);
		rd(6'h12, 2'h2);
		rd(6'h14, 2'h2);
		rd(6'h09, 2'h1);
		rd(6'h0c, 2'h2);
		rd_req = 0;
		@(posedge clk) #2;
		// A read held over a frozen edge must be answered exactly once.
		clk_en = 0;
		rd(6'h24, 2'h2);
		clk_en = 1;
		@(posedge clk) #2;
		rd_req = 0;
		pe(3'h6, 10'h000, 2'h1);
		pe(3'h2, 10'h000, 2'h1);
		pe(3'h4, 10'h000, 2'h1);
		pe(3'h1, 10'h000, 2'h2);
		pe(3'h5, 10'h000, 2'h2);
		pe_req = 0;
		arm(4'h6, 0);
		ul(8'h35 ^ 8'(1 + $urandom % 255), 4'h6, 0, 0, 0);
		ul(8'h35, 4'h5, 0, 0, 0);
		ul(8'h35, 4'h6, 1, 12'h800, 12'hc00);
		ul(8'h35, 4'h6, 0, 0, 0);
		rd(6'h22, 2'h1);
		rd_req = 0;
		pe(3'h6, 10'h000, 2'h1);
		pe_req = 0;
		boot(0, 0, 8'h00);
		rd(6'h22, 2'h2);
		rd_req = 0;
		pe(3'h6, 10'h000, 2'h2);
		pe_req = 0;
		arm(4'h3, 0);
		arm(4'h6, 1);
		boot(0, 1, 8'ha7);
		rd(6'h22, 2'h2);
		rd(6'h14, 2'h2);
		rd(6'h21, 2'h1);
		rd_req = 0;
		pe(3'h1, 10'h000, 2'h1);
		pe(3'h5, 10'h000, 2'h1);
		pe_req = 0;
		ul(8'ha7, 4'h6, 1, 12'hfff, 12'hfff);
		for (int n = 1; n <= 10; n++)
		begin
			p = {1'b0, n[3:0], 3'h5};
			boot(1, 1, p);
			pe(3'h5, 10'h001, 2'h1);
			pe(3'h1, 10'h001, 2'h2);
			pe_req = 0;
			ul(p, 4'h6, 1, (n == 10) ? 12'h3ff : 12'((1 << n) - 1), 12'h3ff);
		end
		boot(1, 1, 8'h9c);
		pe(3'h1, 10'h200, 2'h1);
		pe_req = 0;
		ul(8'h9c, 4'h6, 1, 12'h3ff, 12'h3ff);
		boot(1, 1, 8'h78);
		pe(3'h5, 10'h001, 2'h2);
		pe_req = 0;
		repeat (2) @(posedge clk) #2;
		chk(0, 12'(q_rd.size() + q_pe.size() + q_ul.size() + q_pw.size()));
		results();
	end
endmodule // flash_protection_control_tb
`default_nettype wire
